// ==== hdl/crc_generator.sv ====
// programmable crc generator with input fifo, two-bit-per-cycle shift engine and axi4-lite slave
// assumes one clock, a synchronous active-low reset and a well-behaved axi4-lite master
// Function
// R1 - polynomial order is the five-bit length field plus one, up to 32
// R2 - each set term bit enables the xor at its engine position
// R3 - the zeroth-order term is always applied
// R4 - the highest term of the configured order is always applied
// R5 - input word width is the five-bit width field plus one
// R6 - fifo depth is 4, 8 or 16 words by width field
// R7 - byte-granular input writes, bits above the width ignored
// R8 - word count rises when the byte holding the width msb is written
// R9 - software writes the low input half before the high half
// R10 - while go and words waiting, move one word to the shift buffer
// R11 - engine shifts two bits per cycle until the words run out
// R12 - full flag at depth, empty flag at zero count
// R13 - module enable low empties the fifo and zeroes the count
// R14 - software waits one cycle after an input write before reading count
// R15 - msb first by default, lsb first when direction bit is one
// R16 - direction only orders input bits; remainder stays non-reflected
// R17 - irq select zero: interrupt on word count going from one to zero
// R18 - irq select one: hardware clears go at finish and interrupts
// R19 - software clears the result pair before a fresh computation
// R20 - software enables, configures, preloads, sets go, then refills
// R21 - remainder is readable in the low and high result registers
// R22 - feedback is input bit xor top remainder bit; shift, xor terms
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`default_nettype none
module crc_generator (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire crc_pkg::axi_req_s bus_req_i,
   output crc_pkg::axi_rsp_s bus_rsp_o,
   output logic irq_o
);
   import crc_pkg::*;

   typedef struct packed {
      logic en;
      logic isel;
      logic go;
      logic lsb;
      logic [4:0] width;
      logic [4:0] poly_length_field;
      logic [31:0] terms;
      logic [31:0] inbuf;
      logic [31:0] result;
      logic [FIFO_SLOTS-1:0][31:0] mem;
      logic [3:0] wp;
      logic [3:0] rp;
      logic [4:0] cnt;
      logic busy;
      logic [31:0] sbuf;
      logic [5:0] left;
      logic irq;
      logic aw_got;
      logic [ADDR_W-1:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      axi_rsp_s rsp;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // fifo depth for the configured width
   function automatic logic [4:0] depth_of(input logic [4:0] w);
      if (w > 5'd15) begin
         return DEPTH_WIDE; // R6
      end else if (w >= 5'd8) begin
         return DEPTH_MID; // R6
      end
      return DEPTH_NARROW; // R6
   endfunction

   // ones in the low (field + 1) bits
   function automatic logic [31:0] low_mask(input logic [4:0] f);
      return 32'hffffffff >> (5'd31 - f);
   endfunction

   // byte-lane merge of a 16-bit register image
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // one engine step; the implied top term falls out through the order mask
   function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] terms,
                                            input logic [4:0] poly_length_field, input logic din);
      logic fb;
      logic [31:0] r;
      fb = din ^ crc[poly_length_field]; // R22 R4
      r = crc << 1; // R22
      if (fb) begin
         r = r ^ (terms | 32'h00000001); // R2 R3
      end
      return r & low_mask(poly_length_field); // R1 R4
   endfunction

   // control_reg_one image, flags derived from the count
   function automatic logic [15:0] ctrl1_img(input state_s s);
      logic [15:0] r;
      r = 16'h0000;
      r[MODULE_ENABLE_BIT] = s.en;
      r[COUNT_LSB +: 5] = s.cnt;
      r[FULL_BIT] = (s.cnt == depth_of(s.width)); // R12
      r[EMPTY_BIT] = (s.cnt == 5'd0); // R12
      r[IRQ_SEL_BIT] = s.isel;
      r[GO_BIT] = s.go;
      r[LSB_FIRST_BIT] = s.lsb;
      return r;
   endfunction

   // next-state logic: engine first, then bus writes so software wins a same-cycle clash
   always_comb begin
      logic [15:0] m;
      logic [31:0] rd;
      logic rerr;
      logic push;
      logic din;
      m = 16'h0000;
      rd = 32'h00000000;
      rerr = 1'b0;
      push = 1'b0;
      din = 1'b0;
      st_nxt = st_r;
      st_nxt.irq = 1'b0;

      // shift engine: up to two bits per cycle
      if (st_r.busy) begin
         for (int k = 0; k < BITS_PER_CYCLE; k++) begin
            if (st_nxt.left != 6'd0) begin
               if (st_r.lsb) begin
                  din = st_nxt.sbuf[0]; // R15
                  st_nxt.sbuf = st_nxt.sbuf >> 1;
               end else begin
                  din = st_nxt.sbuf[st_r.width]; // R15 R16
                  st_nxt.sbuf = st_nxt.sbuf << 1;
               end
               st_nxt.result = crc_step(st_nxt.result, st_r.terms, st_r.poly_length_field, din); // R11 R22
               st_nxt.left = st_nxt.left - 6'd1;
            end
         end
         st_nxt.busy = (st_nxt.left != 6'd0);
      end

      // load the next word as soon as the buffer is free, so words run back to back
      if (st_r.go && !st_nxt.busy && st_r.cnt != 5'd0) begin
         st_nxt.sbuf = st_r.mem[st_r.rp]; // R10
         st_nxt.rp = st_r.rp + 4'd1;
         st_nxt.cnt = st_r.cnt - 5'd1; // R10
         st_nxt.left = {1'b0, st_r.width} + 6'd1; // R5
         st_nxt.busy = 1'b1;
      end else if (st_r.go && st_r.busy && !st_nxt.busy && st_r.isel) begin
         st_nxt.go = 1'b0; // R18
         st_nxt.irq = 1'b1; // R18
      end

      // write address and data taken independently
      if (bus_req_i.awvalid && st_r.rsp.awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = bus_req_i.awaddr;
      end
      if (bus_req_i.wvalid && st_r.rsp.wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = bus_req_i.wdata;
         st_nxt.wstrb = bus_req_i.wstrb;
      end
      if (st_r.rsp.bvalid && bus_req_i.bready) begin
         st_nxt.rsp.bvalid = 1'b0;
      end

      // register write once both halves are in
      if (st_nxt.aw_got && st_nxt.w_got && !st_r.rsp.bvalid) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.rsp.bvalid = 1'b1;
         st_nxt.rsp.bresp = RESP_OKAY;
         case ({st_nxt.awaddr[ADDR_W-1:2], 2'b00})
            OFS_CONTROL_REG_ONE: begin
               m = merge16(ctrl1_img(st_nxt), st_nxt.wdata, st_nxt.wstrb);
               st_nxt.en = m[MODULE_ENABLE_BIT];
               st_nxt.isel = m[IRQ_SEL_BIT];
               st_nxt.go = m[GO_BIT]; // software clear gives no interrupt
               st_nxt.lsb = m[LSB_FIRST_BIT];
            end
            OFS_CONTROL_REG_TWO: begin
               m = merge16({3'b000, st_r.width, 3'b000, st_r.poly_length_field}, st_nxt.wdata, st_nxt.wstrb);
               st_nxt.width = m[WIDTH_LSB +: 5]; // R5
               st_nxt.poly_length_field = m[LENGTH_LSB +: 5]; // R1
            end
            OFS_POLY_TERMS_LOW: st_nxt.terms[15:0] = merge16(st_r.terms[15:0], st_nxt.wdata, st_nxt.wstrb);
            OFS_POLY_TERMS_HIGH: st_nxt.terms[31:16] = merge16(st_r.terms[31:16], st_nxt.wdata, st_nxt.wstrb);
            OFS_FIFO_INPUT_LOW: begin
               st_nxt.inbuf[15:0] = merge16(st_r.inbuf[15:0], st_nxt.wdata, st_nxt.wstrb); // R7
               push = (st_r.width < 5'd16) && st_nxt.wstrb[st_r.width[3]]; // R8
            end
            OFS_FIFO_INPUT_HIGH: begin
               st_nxt.inbuf[31:16] = merge16(st_r.inbuf[31:16], st_nxt.wdata, st_nxt.wstrb); // R7
               push = (st_r.width >= 5'd16) && st_nxt.wstrb[st_r.width[3]]; // R8
            end
            OFS_RESULT_LOW: st_nxt.result[15:0] = merge16(st_nxt.result[15:0], st_nxt.wdata, st_nxt.wstrb);
            OFS_RESULT_HIGH: st_nxt.result[31:16] = merge16(st_nxt.result[31:16], st_nxt.wdata, st_nxt.wstrb);
            default: st_nxt.rsp.bresp = RESP_SLVERR;
         endcase
      end

      // a completed word enters the fifo unless it is full; excess words are dropped
      if (push && st_r.en && st_r.cnt < depth_of(st_r.width)) begin
         st_nxt.mem[st_r.wp] = st_nxt.inbuf & low_mask(st_r.width); // R7
         st_nxt.wp = st_r.wp + 4'd1;
         st_nxt.cnt = st_nxt.cnt + 5'd1; // R8
      end

      // word count draining to zero
      if (!st_r.isel && st_r.en && st_r.cnt == 5'd1 && st_nxt.cnt == 5'd0) begin
         st_nxt.irq = 1'b1; // R17
      end

      // disabled module: fifo, pointers and engine held empty
      if (!st_nxt.en) begin
         st_nxt.cnt = 5'd0; // R13
         st_nxt.wp = 4'h0; // R13
         st_nxt.rp = 4'h0; // R13
         st_nxt.busy = 1'b0;
         st_nxt.left = 6'd0;
         st_nxt.inbuf = 32'h00000000;
      end

      // read channel, answered one cycle after the address is taken
      if (st_r.rsp.rvalid && bus_req_i.rready) begin
         st_nxt.rsp.rvalid = 1'b0;
      end
      if (bus_req_i.arvalid && st_r.rsp.arready) begin
         case ({bus_req_i.araddr[ADDR_W-1:2], 2'b00})
            OFS_CONTROL_REG_ONE: rd = {16'h0000, ctrl1_img(st_r)};
            OFS_CONTROL_REG_TWO: rd = {19'h00000, st_r.width, 3'b000, st_r.poly_length_field};
            OFS_POLY_TERMS_LOW: rd = {16'h0000, st_r.terms[15:0]};
            OFS_POLY_TERMS_HIGH: rd = {16'h0000, st_r.terms[31:16]};
            OFS_FIFO_INPUT_LOW: rd = {16'h0000, st_r.inbuf[15:0]};
            OFS_FIFO_INPUT_HIGH: rd = {16'h0000, st_r.inbuf[31:16]};
            OFS_RESULT_LOW: rd = {16'h0000, st_r.result[15:0]}; // R21
            OFS_RESULT_HIGH: rd = {16'h0000, st_r.result[31:16]}; // R21
            default: rerr = 1'b1;
         endcase
         st_nxt.rsp.rvalid = 1'b1;
         st_nxt.rsp.rdata = rd;
         st_nxt.rsp.rresp = rerr ? RESP_SLVERR : RESP_OKAY;
      end

      // readies registered from the next state so each output is a flop
      st_nxt.rsp.awready = !st_nxt.aw_got && !st_nxt.rsp.bvalid;
      st_nxt.rsp.wready = !st_nxt.w_got && !st_nxt.rsp.bvalid;
      st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
   end

   // state register
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus_rsp_o = st_r.rsp;
   assign irq_o = st_r.irq;
endmodule
`default_nettype wire

// ==== hdl/crc_pkg.sv ====
// package for the programmable crc generator: register map, field positions, bus carriers
// assumes a 32-bit axi4-lite master with 8-bit byte addresses
`default_nettype none
package crc_pkg;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFS_CONTROL_REG_ONE = 8'h00;
   localparam logic [7:0] OFS_CONTROL_REG_TWO = 8'h04;
   localparam logic [7:0] OFS_POLY_TERMS_LOW = 8'h08;
   localparam logic [7:0] OFS_POLY_TERMS_HIGH = 8'h0c;
   localparam logic [7:0] OFS_FIFO_INPUT_LOW = 8'h10;
   localparam logic [7:0] OFS_FIFO_INPUT_HIGH = 8'h14;
   localparam logic [7:0] OFS_RESULT_LOW = 8'h18;
   localparam logic [7:0] OFS_RESULT_HIGH = 8'h1c;
   // control_reg_one fields
   localparam int MODULE_ENABLE_BIT = 15;
   localparam int COUNT_LSB = 8;
   localparam int FULL_BIT = 7;
   localparam int EMPTY_BIT = 6;
   localparam int IRQ_SEL_BIT = 5;
   localparam int GO_BIT = 4;
   localparam int LSB_FIRST_BIT = 3;
   // control_reg_two fields
   localparam int WIDTH_LSB = 8;
   localparam int LENGTH_LSB = 0;
   // fifo depths per width class
   localparam logic [4:0] DEPTH_WIDE = 5'h04;
   localparam logic [4:0] DEPTH_MID = 5'h08;
   localparam logic [4:0] DEPTH_NARROW = 5'h10;
   localparam int FIFO_SLOTS = 16;
   localparam int BITS_PER_CYCLE = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_s;
endpackage
`default_nettype wire

// ==== tb/crc_chk.sv ====
// checker for the crc generator: bus answers and status read-back
// assumes one clock and the block's synchronous active-low reset
`default_nettype none
module crc_chk (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire crc_pkg::axi_req_s bus_req_i,
   input wire crc_pkg::axi_rsp_s bus_rsp_o,
   input wire logic irq_o
);
   import crc_pkg::*;
   logic [7:0] ar_q;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // address of the read in flight, so its data can be decoded
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         ar_q <= 8'h00;
      end else if (bus_req_i.arvalid && bus_rsp_o.arready) begin
         ar_q <= bus_req_i.araddr;
      end
   end
   sequence s_ar_taken;
      bus_req_i.arvalid && bus_rsp_o.arready;
   endsequence
   sequence s_ctrl_data;
      bus_rsp_o.rvalid && ar_q == OFS_CONTROL_REG_ONE;
   endsequence
   property p_rd_answer;
      s_ar_taken |=> bus_rsp_o.rvalid && !bus_rsp_o.arready;
   endproperty
   property p_rd_hold;
      bus_rsp_o.rvalid && !bus_req_i.rready |=> bus_rsp_o.rvalid && $stable(bus_rsp_o.rdata);
   endproperty
   property p_wr_answer;
      bus_req_i.awvalid && bus_rsp_o.awready && bus_req_i.wvalid && bus_rsp_o.wready |=> bus_rsp_o.bvalid;
   endproperty
   property p_wr_hold;
      bus_rsp_o.bvalid && !bus_req_i.bready |=> bus_rsp_o.bvalid && $stable(bus_rsp_o.bresp) && !bus_rsp_o.awready;
   endproperty
   property p_unmapped;
      s_ar_taken ##0 bus_req_i.araddr > OFS_RESULT_HIGH |=> bus_rsp_o.rresp == RESP_SLVERR && bus_rsp_o.rdata == 0;
   endproperty
   property p_empty;
      s_ctrl_data |-> bus_rsp_o.rdata[EMPTY_BIT] == (bus_rsp_o.rdata[12:8] == 5'h00);
   endproperty
   property p_full;
      s_ctrl_data ##0 bus_rsp_o.rdata[FULL_BIT] |-> bus_rsp_o.rdata[12:8] inside {5'h04, 5'h08, 5'h10};
   endproperty
   property p_depth;
      s_ctrl_data |-> bus_rsp_o.rdata[12:8] <= 5'h10;
   endproperty
   property p_upper;
      bus_rsp_o.rvalid |-> bus_rsp_o.rdata[31:16] == 16'h0000;
   endproperty
   // two interrupt causes land on adjacent edges only when a write sets irq select, keeping go, as a last one- or two-bit word loads
   property p_irq_pulse;
      irq_o |=> !irq_o;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   a_wr_hold: assert property (p_wr_hold) else $error("write answer moved");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
   a_empty: assert property (p_empty) else $error("empty flag wrong");
   a_full: assert property (p_full) else $error("full flag at odd count");
   a_depth: assert property (p_depth) else $error("count beyond deepest fifo");
   a_upper: assert property (p_upper) else $error("upper read bits set");
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
endmodule
bind crc_generator crc_chk chk_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req_i),
   .bus_rsp_o(bus_rsp_o), .irq_o(irq_o));
`default_nettype wire

// ==== tb/tb_top.sv ====
// bench for the crc generator: axi4-lite register tasks and crc runs
// assumes the checker file is compiled with it and binds itself
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import crc_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   axi_req_s req = '0;
   axi_rsp_s rsp;
   logic irq;
   logic [31:0] d;
   logic [1:0] r;
   int miscompares = 0;
   int checks = 0;
   int k;
   always #5 core_clk_i = ~core_clk_i;
   crc_generator dut_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .bus_req_i(req), .bus_rsp_o(rsp), .irq_o(irq));
   // answers are looked at on the falling edge, acted on at the next rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw_t, w_t, b_t;
      @(posedge core_clk_i);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'h3;
      req.bready <= 1'b1;
      do begin
         @(negedge core_clk_i);
         aw_t = req.awvalid && rsp.awready;
         w_t = req.wvalid && rsp.wready;
         b_t = rsp.bvalid;
         @(posedge core_clk_i);
         if (aw_t) req.awvalid <= 1'b0;
         if (w_t) req.wvalid <= 1'b0;
      end while (!b_t);
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      logic a_t, r_t;
      @(posedge core_clk_i);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(negedge core_clk_i);
         a_t = req.arvalid && rsp.arready;
         r_t = rsp.rvalid;
         v = rsp.rdata;
         e = rsp.rresp;
         @(posedge core_clk_i);
         if (a_t) req.arvalid <= 1'b0;
      end while (!r_t);
      req.rready <= 1'b0;
   endtask
   // bitwise reference: remainder kept non-reflected whatever the input order
   function automatic logic [31:0] step(input logic [31:0] rm, input logic [31:0] w, input int wd, input int od,
      input logic [31:0] t, input logic lsb);
      logic b;
      for (int i = 0; i < wd; i++) begin
         b = lsb ? w[i] : w[wd-1-i];
         rm = (b ^ rm[od-1]) ? (rm << 1) ^ (t | 32'h1) : rm << 1;
      end
      return od == 32 ? rm : rm & ((32'h1 << od) - 1);
   endfunction
   task automatic wait_irq();
      logic seen;
      seen = 1'b0;
      for (int n = 0; n < 400 && !seen; n++) begin
         #1;
         seen = irq === 1'b1;
         if (!seen) @(posedge core_clk_i);
      end
      `CHK(seen, 1'b1)
   endtask
   // one computation: configure, preload n words (past full when n exceeds the depth), go, read the remainder
   task automatic run(input logic [4:0] wf, input logic [4:0] lf, input logic [31:0] t, input logic lsb, input int n);
      logic [31:0] w, x, lo;
      logic [1:0] e;
      int dp;
      dp = wf > 15 ? 4 : wf > 7 ? 8 : 16;
      x = 32'h0;
      wr(OFS_CONTROL_REG_TWO, {19'h0, wf, 3'h0, lf});
      wr(OFS_POLY_TERMS_LOW, {16'h0, t[15:0]});
      wr(OFS_POLY_TERMS_HIGH, {16'h0, t[31:16]});
      wr(OFS_RESULT_LOW, 32'h0);
      wr(OFS_RESULT_HIGH, 32'h0);
      for (int i = 0; i < n; i++) begin
         w = 32'hc3a5_f00f ^ (i * 32'h1357_9bdf);
         wr(OFS_FIFO_INPUT_LOW, {16'h0, w[15:0]});
         if (wf > 15) wr(OFS_FIFO_INPUT_HIGH, {16'h0, w[31:16]});
         if (i < dp) x = step(x, w, wf + 1, lf + 1, t, lsb);
      end
      rd(OFS_CONTROL_REG_ONE, w, e);
      `CHK(w[12:8], 5'(n < dp ? n : dp))
      `CHK(w[FULL_BIT], n >= dp)
      wr(OFS_CONTROL_REG_ONE, {16'h0, 12'h803, lsb, 3'h0});
      wait_irq();
      rd(OFS_RESULT_LOW, lo, e);
      rd(OFS_RESULT_HIGH, w, e);
      `CHK({w[15:0], lo[15:0]}, x)
      rd(OFS_CONTROL_REG_ONE, w, e);
      `CHK(w[GO_BIT], 1'b0)
   endtask
   task automatic conclude();
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // the whole run needs well under a thousand cycles
   initial begin
      #100us;
      miscompares++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rd(OFS_CONTROL_REG_ONE, d, r);
      `CHK(d, 32'h0000_0040)
      rd(8'h24, d, r);
      `CHK(r, RESP_SLVERR)
      wr(OFS_CONTROL_REG_ONE, 32'h0000_8000);
      run(5'd7, 5'h0f, 32'h0000_1020, 1'b0, 3);
      run(5'd5, 5'h0f, 32'h0000_1020, 1'b1, 17);
      run(5'd15, 5'h0f, 32'h0000_1021, 1'b0, 9);
      run(5'd31, 5'h1f, 32'h04c1_1db6, 1'b0, 5);
      wr(OFS_FIFO_INPUT_LOW, 32'h0000_00aa);
      wr(OFS_FIFO_INPUT_HIGH, 32'h0000_0055);
      wr(OFS_CONTROL_REG_ONE, 32'h0);
      rd(OFS_CONTROL_REG_ONE, d, r);
      `CHK(d[12:6], 7'h01)
      wr(OFS_CONTROL_REG_ONE, 32'h0000_8000);
      wr(OFS_FIFO_INPUT_LOW, 32'h0000_00aa);
      wr(OFS_FIFO_INPUT_HIGH, 32'h0000_0055);
      wr(OFS_CONTROL_REG_ONE, 32'h0000_8010);
      wait_irq();
      repeat (30) @(posedge core_clk_i);
      // a 32-bit word shifts for 16 cycles; go cleared by software mid-word must stay silent
      wr(OFS_FIFO_INPUT_LOW, 32'h0000_00aa);
      wr(OFS_FIFO_INPUT_HIGH, 32'h0000_0055);
      wr(OFS_CONTROL_REG_ONE, 32'h0000_8030);
      wr(OFS_CONTROL_REG_ONE, 32'h0000_8020);
      k = 0;
      repeat (20) begin
         @(posedge core_clk_i);
         #1;
         if (irq === 1'b1) k++;
      end
      `CHK(k, 0)
      conclude();
   end
endmodule
`default_nettype wire
